// *** common/trct_pkg.sv ***
// Constants and carrier types for the three-channel reload/capture timer bank
package trct_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_TIMERS = 3;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 4;
  localparam int PRE_W      = 12;
  localparam int FAST_W     = 3;

  // ==========================================================
  // Register word index within one timer (address bits 1:0)
  localparam logic [1:0] REG_COUNT = 2'h0;
  localparam logic [1:0] REG_RCA   = 2'h1;
  localparam logic [1:0] REG_RCB   = 2'h2;
  localparam logic [1:0] REG_CTL   = 2'h3;

  // ==========================================================
  // Control register field positions
  localparam int CTL_IEN_B   = 0;
  localparam int CTL_IPF_B   = 1;
  localparam int CTL_IEN_A   = 2;
  localparam int CTL_IPF_A   = 3;
  localparam int CTL_RUN     = 4;
  localparam int CTL_MODE_LO = 5;
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_PRE     = 8;
  localparam int CTL_WI_B    = 9;
  localparam int CTL_WI_A    = 10;
  localparam int CTL_WI_RUN  = 11;

  // ==========================================================
  // Mode codes, the zero reset value and the all-ones mode 3 reload value
  localparam logic [2:0]  MODE_RELOAD  = 3'h1;
  localparam logic [2:0]  MODE_CAPTURE = 3'h2;
  localparam logic [2:0]  MODE_FREE    = 3'h3;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [15:0] ALL_ONES     = 16'hFFFF;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic              sel;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } trct_req_s;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } trct_rsp_s;

  typedef struct packed {
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] rca;
    logic [DATA_W-1:0] rcb;
    logic              ien_b;
    logic              ipf_b;
    logic              ien_a;
    logic              ipf_a;
    logic              run;
    logic [2:0]        mode;
    logic              pre;
  } trct_tmr_s;

  typedef struct packed {
    trct_tmr_s [NUM_TIMERS-1:0] tm;
    logic [PRE_W-1:0]           div;
    logic [NUM_TIMERS-1:0]      cap_s1;
    logic [NUM_TIMERS-1:0]      cap_s2;
    logic [NUM_TIMERS-1:0]      cap_d;
    trct_rsp_s                  rsp;
    logic [NUM_TIMERS-1:0]      irq;
  } trct_state_s;
endpackage

// *** dv/trct_testbench.sv ***
// Self-checking register-level bench for the three-channel reload/capture timer bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
  // ==========================================================
  // Signals
  logic                            clk;
  logic                            rst_b;
  trct_pkg::trct_req_s             bus_req;
  trct_pkg::trct_rsp_s             bus_rsp;
  logic [trct_pkg::NUM_TIMERS-1:0] capture_pin;
  logic [trct_pkg::NUM_TIMERS-1:0] irq;
  int                              fail_count;
  int                              check_count;
  logic [15:0]                     q;
  int                              n;

  trct_timer_bank u_trct_timer_bank (
    .clk         (clk),
    .rst_b       (rst_b),
    .bus_req     (bus_req),
    .bus_rsp     (bus_rsp),
    .capture_pin (capture_pin),
    .irq         (irq)
  );

  // ==========================================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  // Word address of register r in timer t
  function automatic logic [3:0] adr(input int t, input logic [1:0] r);
    return {t[1:0], r};
  endfunction

  // 16-bit word accesses only
  // One access: request for one cycle, answer sampled one edge later
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] rd);
    @(posedge clk);
    bus_req <= '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(posedge clk);
    bus_req.sel <= 1'b0;
    #1;
    `CHK("ack", 1'b1, bus_rsp.ack)
    rd = bus_rsp.rdata;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic chk_rd(input string nm, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] rd;
    xfer(1'b0, a, 16'h0000, rd);
    `CHK(nm, exp, rd)
  endtask

  // Bounded wait for an interrupt line, cycles counted in cnt
  task automatic wait_irq(input int i, input int lim, output int cnt);
    cnt = 0;
    while (irq[i] !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    `CHK("irq", 1'b1, irq[i])
  endtask

  task automatic end_sim;
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog, well beyond two slow prescaler periods
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_b       = 1'b0;
    bus_req     = '0;
    capture_pin = '0;
    fail_count  = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // Reset contents, unmapped timer included
    for (int t = 0; t < 4; t++) begin
      for (int r = 0; r < 4; r++) begin
        chk_rd("reset", adr(t, 2'(r)), 16'h0000);
      end
    end
    // Independent 16-bit storage per timer
    for (int t = 0; t < 3; t++) begin
      for (int r = 0; r < 3; r++) begin
        wr(adr(t, 2'(r)), 16'hF00F ^ {6'h00, 2'(r), 2'(t), 6'h00});
      end
    end
    for (int t = 0; t < 3; t++) begin
      for (int r = 0; r < 3; r++) begin
        chk_rd("word", adr(t, 2'(r)), 16'hF00F ^ {6'h00, 2'(r), 2'(t), 6'h00});
      end
    end
    wr(adr(3, trct_pkg::REG_RCA), 16'h1234);
    chk_rd("unmapped", adr(3, trct_pkg::REG_RCA), 16'h0000);
    // Flags, enables and write inhibits on timer 0 in mode 0
    wr(adr(0, trct_pkg::REG_CTL), 16'h001F);
    chk_rd("ctl", adr(0, trct_pkg::REG_CTL), 16'h001F);
    `CHK("irq_b", 1'b1, irq[0])
    wr(adr(0, trct_pkg::REG_CTL), 16'h0E00);
    chk_rd("inhibit", adr(0, trct_pkg::REG_CTL), 16'h001A);
    `CHK("masked", 1'b0, irq[0])
    wr(adr(0, trct_pkg::REG_CTL), 16'h0000);
    chk_rd("clear", adr(0, trct_pkg::REG_CTL), 16'h0000);
    // Frozen counters: mode 7 with run on, mode 0, and mode 1 with run off
    wr(adr(1, trct_pkg::REG_CTL), 16'h0020);
    wr(adr(2, trct_pkg::REG_CTL), 16'h00F0);
    repeat (20) @(posedge clk);
    chk_rd("mode7", adr(2, trct_pkg::REG_COUNT), 16'hF08F);
    chk_rd("mode0", adr(0, trct_pkg::REG_COUNT), 16'hF00F);
    chk_rd("stopped", adr(1, trct_pkg::REG_COUNT), 16'hF04F);
    // Mode 1 underflow reloads from A and sets pending A
    wr(adr(0, trct_pkg::REG_COUNT), 16'h0000);
    wr(adr(0, trct_pkg::REG_RCA), 16'h0005);
    wr(adr(0, trct_pkg::REG_CTL), 16'h0035);
    wait_irq(0, 12, n);
    chk_rd("reload", adr(0, trct_pkg::REG_COUNT), 16'h0005);
    chk_rd("pend_a", adr(0, trct_pkg::REG_CTL), 16'h003D);
    // Mode 3 underflow loads all ones and sets the run flag
    wr(adr(1, trct_pkg::REG_COUNT), 16'h0000);
    wr(adr(1, trct_pkg::REG_CTL), 16'h0064);
    wait_irq(1, 12, n);
    chk_rd("ones", adr(1, trct_pkg::REG_COUNT), trct_pkg::ALL_ONES);
    chk_rd("uflow", adr(1, trct_pkg::REG_CTL), 16'h0074);
    // Mode 3 capture into A with pending A, underflow flag cleared first
    wr(adr(1, trct_pkg::REG_CTL), 16'h0064);
    @(posedge clk);
    capture_pin[1] <= 1'b1;
    wait_irq(1, 10, n);
    @(posedge clk);
    capture_pin[1] <= 1'b0;
    xfer(1'b0, adr(1, trct_pkg::REG_RCA), 16'h0000, q);
    `CHK("capture_a", 1'b1, q >= 16'hFFF0)
    chk_rd("pend_a3", adr(1, trct_pkg::REG_CTL), 16'h006C);
    // Mode 2 capture into B with pending B
    wr(adr(2, trct_pkg::REG_RCA), 16'h0064);
    wr(adr(2, trct_pkg::REG_COUNT), 16'h0064);
    wr(adr(2, trct_pkg::REG_CTL), 16'h0051);
    @(posedge clk);
    capture_pin[2] <= 1'b1;
    wait_irq(2, 10, n);
    @(posedge clk);
    capture_pin[2] <= 1'b0;
    xfer(1'b0, adr(2, trct_pkg::REG_RCB), 16'h0000, q);
    `CHK("capture", 1'b1, q <= 16'h0064 && q >= 16'h0060)
    // Slow prescaler: stop, zero the counter so the first slow tick underflows
    wr(adr(0, trct_pkg::REG_CTL), 16'h0000);
    wr(adr(0, trct_pkg::REG_COUNT), 16'h0000);
    wr(adr(0, trct_pkg::REG_RCA), 16'h0000);
    wr(adr(0, trct_pkg::REG_CTL), 16'h0134);
    wait_irq(0, 4200, n);
    wr(adr(0, trct_pkg::REG_CTL), 16'h0134);
    wait_irq(0, 4200, n);
    `CHK("slow_gap", 1'b1, n > 4087 && n < 4097)
    end_sim();
  end
endmodule // testbench

// *** hdl/trct_timer_bank.sv ***
// Three 16-bit down-counting timers with reload/capture registers
`timescale 1ns/1ps

// Behaviour
// - Three independent timers, each with four 16-bit registers.
// - The counter counts down and reloads from register A on underflow in modes 1 and 2.
// - In mode 3 the counter reloads with all ones on underflow.
// - Register A holds a reload value or a mode 3 counter snapshot; register B holds a mode 2 counter snapshot.
// - Pending flag B raises an interrupt only while enable B is set.
// - Pending flag A, and in mode 3 the underflow flag, raise an interrupt while enable A is set.
// - In modes 1 and 2 the run bit starts and stops the counter.
// - In mode 3 the run bit is the underflow pending flag, set on underflow.
// - Control bits 7 to 5 select the operating mode.
// - A control write with bit 9 set leaves pending flag B unchanged.
// - A control write with bit 10 set leaves pending flag A unchanged.
// - A control write with bit 11 set leaves the run bit unchanged.
module trct_timer_bank (
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  input  wire trct_pkg::trct_req_s                 bus_req,
  output      trct_pkg::trct_rsp_s                 bus_rsp,
  input  wire logic [trct_pkg::NUM_TIMERS-1:0]     capture_pin,
  output      logic [trct_pkg::NUM_TIMERS-1:0]     irq
);

  // ==========================================================
  // State
  trct_pkg::trct_state_s              st;
  trct_pkg::trct_state_s              next_st;
  logic [trct_pkg::NUM_TIMERS-1:0]    tick_v;
  logic [trct_pkg::NUM_TIMERS-1:0]    hit_v;
  logic [trct_pkg::NUM_TIMERS-1:0]    cap_e;
  logic                               tick_fast;
  logic                               tick_slow;

  assign bus_rsp = st.rsp;
  assign irq     = st.irq;

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [1:0]              rg;
    logic                    wr;
    logic                    runs;
    logic [15:0]             wd;
    trct_pkg::trct_tmr_s     t;
    trct_pkg::trct_tmr_s     n;
    rg = bus_req.addr[1:0];
    wd = bus_req.wdata;
    wr = 1'b0;
    runs = 1'b0;
    t = st.tm[0];
    n = st.tm[0];
    next_st = st;
    tick_v = '0;
    hit_v = '0;
    // Shared divider for the two prescaled rates
    next_st.div = st.div + 1'b1;
    tick_fast = (st.div[trct_pkg::FAST_W-1:0] == '1);
    tick_slow = (st.div == '1);
    // Capture pins: two-stage sync, then edge detect on the second stage
    next_st.cap_s1 = capture_pin;
    next_st.cap_s2 = st.cap_s1;
    next_st.cap_d = st.cap_s2;
    cap_e = st.cap_s2 & ~st.cap_d;
    // Every access is answered one cycle later; unmapped reads return zero
    next_st.rsp.ack = bus_req.sel;
    next_st.rsp.rdata = '0;
    for (int i = 0; i < trct_pkg::NUM_TIMERS; i++) begin
      t = st.tm[i];
      n = st.tm[i];
      hit_v[i] = bus_req.sel && (bus_req.addr[3:2] == 2'(i));
      wr = hit_v[i] && bus_req.wr;
      if ((t.mode != trct_pkg::MODE_CAPTURE) && t.pre) begin
        tick_v[i] = tick_slow;
      end else begin
        tick_v[i] = tick_fast;
      end
      runs = (t.mode == trct_pkg::MODE_FREE) ||
             (((t.mode == trct_pkg::MODE_RELOAD) || (t.mode == trct_pkg::MODE_CAPTURE)) && t.run);
      // Register reads
      if (hit_v[i] && !bus_req.wr) begin
        case (rg)
          trct_pkg::REG_COUNT: begin
            next_st.rsp.rdata = t.count;
          end
          trct_pkg::REG_RCA: begin
            next_st.rsp.rdata = t.rca;
          end
          trct_pkg::REG_RCB: begin
            next_st.rsp.rdata = t.rcb;
          end
          default: begin
            next_st.rsp.rdata = {7'h00, t.pre, t.mode, t.run, t.ipf_a, t.ien_a, t.ipf_b, t.ien_b};
          end
        endcase
      end
      // Register writes
      if (wr) begin
        case (rg)
          trct_pkg::REG_COUNT: begin
            n.count = wd;
          end
          trct_pkg::REG_RCA: begin
            n.rca = wd;
          end
          trct_pkg::REG_RCB: begin
            n.rcb = wd;
          end
          default: begin
            n.ien_b = wd[trct_pkg::CTL_IEN_B];
            n.ien_a = wd[trct_pkg::CTL_IEN_A];
            n.mode = wd[trct_pkg::CTL_MODE_HI:trct_pkg::CTL_MODE_LO];
            n.pre = wd[trct_pkg::CTL_PRE];
            if (!wd[trct_pkg::CTL_WI_B]) begin
              n.ipf_b = wd[trct_pkg::CTL_IPF_B];
            end
            if (!wd[trct_pkg::CTL_WI_A]) begin
              n.ipf_a = wd[trct_pkg::CTL_IPF_A];
            end
            if (!wd[trct_pkg::CTL_WI_RUN]) begin
              n.run = wd[trct_pkg::CTL_RUN];
            end
          end
        endcase
      end
      // Counting; a software load of the counter wins over a tick
      if (runs && tick_v[i] && !(wr && (rg == trct_pkg::REG_COUNT))) begin
        if (t.count == trct_pkg::WORD_RST) begin
          if (t.mode == trct_pkg::MODE_FREE) begin
            n.count = trct_pkg::ALL_ONES;
            n.run = 1'b1;
          end else begin
            n.count = t.rca;
            n.ipf_a = 1'b1;
          end
        end else begin
          n.count = t.count - 1'b1;
        end
      end
      if (cap_e[i] && (t.mode == trct_pkg::MODE_CAPTURE)) begin
        n.rcb = t.count;
        n.ipf_b = 1'b1;
      end else if (cap_e[i] && (t.mode == trct_pkg::MODE_FREE)) begin
        n.rca = t.count;
        n.ipf_a = 1'b1;
      end
      next_st.tm[i] = n;
      next_st.irq[i] = (n.ipf_b && n.ien_b) || (n.ipf_a && n.ien_a) ||
                       ((n.mode == trct_pkg::MODE_FREE) && n.run && n.ien_a);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Assertions on timer 0
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_irq_b;
    st.tm[0].ipf_b && st.tm[0].ien_b |-> irq[0];
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("enabled pending B without request");

  property p_irq_a;
    st.tm[0].ipf_a && st.tm[0].ien_a |-> irq[0];
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("enabled pending A without request");

  property p_irq_under;
    (st.tm[0].mode == trct_pkg::MODE_FREE) && st.tm[0].run && st.tm[0].ien_a |-> irq[0];
  endproperty
  a_irq_under: assert property (p_irq_under) else $error("underflow flag without request");

  property p_irq_quiet;
    !(st.tm[0].ipf_b && st.tm[0].ien_b) && !(st.tm[0].ipf_a && st.tm[0].ien_a) &&
    !((st.tm[0].mode == trct_pkg::MODE_FREE) && st.tm[0].run && st.tm[0].ien_a) |-> !irq[0];
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("request without a cause");

  property p_free_wrap;
    (st.tm[0].mode == trct_pkg::MODE_FREE) && tick_v[0] && (st.tm[0].count == trct_pkg::WORD_RST) && !hit_v[0]
      |=> (st.tm[0].count == trct_pkg::ALL_ONES) && st.tm[0].run;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("mode 3 underflow wrong");

  property p_reload;
    (st.tm[0].mode == trct_pkg::MODE_RELOAD) && st.tm[0].run && tick_v[0] &&
    (st.tm[0].count == trct_pkg::WORD_RST) && !hit_v[0]
      |=> (st.tm[0].count == $past(st.tm[0].rca)) && st.tm[0].ipf_a;
  endproperty
  a_reload: assert property (p_reload) else $error("mode 1 reload wrong");

  property p_halt;
    (!st.tm[0].run || (st.tm[0].mode == '0) || (st.tm[0].mode > trct_pkg::MODE_FREE)) &&
    (st.tm[0].mode != trct_pkg::MODE_FREE) && !hit_v[0] |=> $stable(st.tm[0].count);
  endproperty
  a_halt: assert property (p_halt) else $error("stopped counter moved");

  property p_wi_b;
    hit_v[0] && bus_req.wr && (bus_req.addr[1:0] == trct_pkg::REG_CTL) && bus_req.wdata[trct_pkg::CTL_WI_B] &&
    (st.tm[0].mode != trct_pkg::MODE_CAPTURE) |=> $stable(st.tm[0].ipf_b);
  endproperty
  a_wi_b: assert property (p_wi_b) else $error("inhibited pending B changed");

  property p_wi_a;
    hit_v[0] && bus_req.wr && (bus_req.addr[1:0] == trct_pkg::REG_CTL) && bus_req.wdata[trct_pkg::CTL_WI_A]
      |=> st.tm[0].ipf_a || !$past(st.tm[0].ipf_a);
  endproperty
  a_wi_a: assert property (p_wi_a) else $error("inhibited pending A cleared");

  property p_wi_run;
    hit_v[0] && bus_req.wr && (bus_req.addr[1:0] == trct_pkg::REG_CTL) && bus_req.wdata[trct_pkg::CTL_WI_RUN]
      |=> st.tm[0].run || !$past(st.tm[0].run);
  endproperty
  a_wi_run: assert property (p_wi_run) else $error("inhibited run bit cleared");

  property p_slow;
    (st.tm[0].mode == trct_pkg::MODE_RELOAD) && st.tm[0].pre |-> (tick_v[0] == tick_slow);
  endproperty
  a_slow: assert property (p_slow) else $error("prescale select ignored");

  c_free_wrap: cover property ((st.tm[0].mode == trct_pkg::MODE_FREE) && tick_v[0] &&
                               (st.tm[0].count == trct_pkg::WORD_RST));
  c_capture: cover property (cap_e[0] && (st.tm[0].mode == trct_pkg::MODE_CAPTURE));
  c_irq_rise: cover property (!irq[0] ##1 irq[0]);

endmodule // trct_timer_bank
